// File: adc_pair_conversion_control_test.sv
`timescale 1ns/1ps
module adc_pair_conversion_control_test;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] start_req = 3'h0, start_hold = 3'h0;
  logic standby_req_n = 1'b1, sw_mode_req = 1'b0, reset_req = 1'b0, span_drive_en = 1'b1;
  logic span_level = 1'b0, ctrl_wr = 1'b0, int_conv_clk = 1'b0;
  logic [31:0] ctrl_wdata = 32'h0, control_register;
  logic [2:0] pair_busy, pair_done, pair_pdown, span_narrow;
  logic ext_clk_level, powered_down, sw_mode, reset_busy;
  logic [2:0] exp_q[$];
  int err_count = 0;
  int num_checks = 0;
  int unsigned r;

  conv_ctrl_if link();
  conv_ctrl_device i_conv_ctrl_device (.clk_sys, .rst_b, .link, .ctrl_wr, .ctrl_wdata,
    .int_conv_clk, .control_register, .pair_busy, .pair_done, .pair_pdown, .span_narrow,
    .ext_clk_level, .powered_down, .sw_mode);
  conv_ctrl_host i_conv_ctrl_host (.clk_sys, .rst_b, .link, .start_req, .start_hold,
    .standby_req_n, .sw_mode_req, .reset_req, .span_drive_en, .span_level, .reset_busy);
  conv_ctrl_asserts i_conv_ctrl_asserts (.clk_sys, .rst_b, .conv_start(link.conv_start),
    .standby_n(link.standby_n), .reset(link.reset), .span_dev_oe(link.span_dev_oe),
    .pin_or_register_control_select(link.pin_or_register_control_select),
    .span_or_conv_clock_pin(link.span_or_conv_clock_pin), .control_register, .pair_busy,
    .pair_pdown, .pair_done, .span_narrow, .powered_down, .sw_mode);

  // System clock and a toggling internal conversion clock.
  initial forever #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) int_conv_clk <= ~int_conv_clk;

  task check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  // Raises and holds the start lines of the pairs in the mask.
  task pulse(input logic [2:0] m);
    cyc(1);
    start_hold <= m;
    start_req <= m;
    cyc(1);
    start_req <= 3'h0;
  endtask : pulse

  task wait_done;
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 300)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 300)
    begin
      err_count++;
      give_verdict();
    end
  endtask : wait_done

  // Each completion pulse is compared with the oldest expected pair mask.
  always @(negedge clk_sys)
    if (rst_b && (|pair_done))
      check(64'(pair_done), 64'(exp_q.pop_front()));

  // Main sequence.
  initial
  begin
    r = $urandom(32'h0D2FDA40);
    cyc(12);
    rst_b <= 1'b1;
    cyc(4);
    @(negedge clk_sys) check(64'(control_register), 64'h3FF);
    for (int i = 0; i < 4; i++)
    begin
      r = $urandom_range(7, 1);
      exp_q.push_back(r[2:0]);
      pulse(r[2:0]);
      wait_done();
      cyc(1);
      start_hold <= 3'h0;
      cyc(4);
      @(negedge clk_sys) check(64'(pair_busy), 64'h0);
    end
    pulse(3'h1);
    cyc(20);
    start_hold <= 3'h0;
    cyc(8);
    @(negedge clk_sys) check(64'(pair_pdown[0]), 64'h1);
    for (int v = 0; v < 2; v++)
    begin
      cyc(1);
      span_level <= ~v[0];
      cyc(6);
      @(negedge clk_sys) check(64'(span_narrow), 64'({3{~v[0]}}));
    end
    cyc(1);
    standby_req_n <= 1'b0;
    cyc(6);
    pulse(3'h1);
    cyc(8);
    @(negedge clk_sys) check(64'({powered_down, pair_busy}), 64'h8);
    cyc(1);
    standby_req_n <= 1'b1;
    start_hold <= 3'h0;
    sw_mode_req <= 1'b1;
    span_drive_en <= 1'b0;
    cyc(6);
    @(negedge clk_sys) check(64'(sw_mode), 64'h1);
    pulse(3'h5);
    cyc(8);
    @(negedge clk_sys) check(64'(pair_busy), 64'h0);
    // The host drives the shared pin high as an external clock level.
    cyc(1);
    start_hold <= 3'h0;
    span_drive_en <= 1'b1;
    span_level <= 1'b1;
    cyc(5);
    @(negedge clk_sys) check(64'(ext_clk_level), 64'h1);
    check(64'(span_narrow), 64'h0);
    cyc(1);
    span_drive_en <= 1'b0;
    span_level <= 1'b0;
    ctrl_wr <= 1'b1;
    ctrl_wdata <= 32'h009003FF;
    cyc(1);
    ctrl_wr <= 1'b0;
    cyc(3);
    @(negedge clk_sys) check(64'({link.span_dev_oe, control_register}), 64'h1009003FF);
    check(64'(link.span_or_conv_clock_pin), 64'({~int_conv_clk}));
    exp_q.push_back(3'h4);
    pulse(3'h4);
    wait_done();
    cyc(1);
    start_hold <= 3'h0;
    cyc(4);
    pulse(3'h4);
    cyc(10);
    reset_req <= 1'b1;
    cyc(1);
    reset_req <= 1'b0;
    @(negedge clk_sys) check(64'(reset_busy), 64'h1);
    cyc(7);
    @(negedge clk_sys) check(64'({pair_busy, control_register}), 64'h3FF);
    cyc(70);
    give_verdict();
  end
endmodule : adc_pair_conversion_control_test

// File: conv_ctrl_asserts.sv
`timescale 1ns/1ps
module conv_ctrl_asserts (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [2:0] conv_start,
  input wire logic standby_n,
  input wire logic pin_or_register_control_select,
  input wire logic reset,
  input wire logic span_or_conv_clock_pin,
  input wire logic span_dev_oe,
  input wire logic [31:0] control_register,
  input wire logic [2:0] pair_busy,
  input wire logic [2:0] pair_pdown,
  input wire logic [2:0] pair_done,
  input wire logic [2:0] span_narrow,
  input wire logic powered_down,
  input wire logic sw_mode
);
  // All checks share the system clock and its reset.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // A rising start on an idle pair in pin mode leads to busy four cycles later.
  start_busy_a: assert property ($rose(conv_start[0]) && !pin_or_register_control_select
    && standby_n && !reset && !pair_busy[0] |-> ##4 pair_busy[0])
    else $error("pair A did not start");
  early_drop_a: assert property (pair_busy[0] && $fell(conv_start[0]) |-> ##[1:5] pair_pdown[0])
    else $error("pair A not powered down after early drop");
  seq_gate_a: assert property (pin_or_register_control_select && sw_mode
    && !control_register[23] && $rose(conv_start[2]) |-> ##4 !pair_busy[2])
    else $error("pair C started outside sequential mode");
  standby_off_a: assert property (!standby_n [*5] |-> powered_down && pair_busy == 3'h0)
    else $error("standby did not power down");
  span_follow_a: assert property ((!pin_or_register_control_select
    && $stable(span_or_conv_clock_pin)) [*5] |-> span_narrow == {3{span_or_conv_clock_pin}})
    else $error("span does not follow pin");
  clock_dir_a: assert property ((sw_mode && $stable(control_register)) [*3]
    |-> span_dev_oe == control_register[20])
    else $error("clock pin direction wrong");
  mode_select_a: assert property ($stable(pin_or_register_control_select) [*4]
    |-> sw_mode == pin_or_register_control_select)
    else $error("mode does not follow select pin");
  reset_abort_a: assert property ($rose(reset) |-> ##5 pair_busy == 3'h0
    && control_register == conv_ctrl_pkg::CTRL_RESET_VAL)
    else $error("reset did not abort and reload");
  reset_width_a: assert property ($rose(reset) |-> reset [*3])
    else $error("reset pulse too short");

  // Main scenarios reached.
  cover property ($rose(pair_busy[0]));
  cover property (pair_done[2]);
  cover property ($rose(pair_pdown[0]));
endmodule : conv_ctrl_asserts

// File: conv_ctrl_device.sv
// Operation
// - Hardware mode: rising start edge converts pair
// - Start dropping early puts pair into power-down
// - Software mode: pair C starts only when sequential
// - Standby low powers everything down
// - Hardware mode: range pin low wide, high narrow
// - Software mode: range pin is clock in/out
// - Reset high aborts all conversions
// - Reset loads control register with 0x000003FF
// - Host holds reset at least 50 ns
// - Mode pin low hardware, high software
`timescale 1ns/1ps
module conv_ctrl_device (
  input wire logic clk_sys,
  input wire logic rst_b,
  conv_ctrl_if.device link,
  input wire logic ctrl_wr,
  input wire logic [31:0] ctrl_wdata,
  input wire logic int_conv_clk,
  output logic [31:0] control_register,
  output logic [2:0] pair_busy,
  output logic [2:0] pair_done,
  output logic [2:0] pair_pdown,
  output logic [2:0] span_narrow,
  output logic ext_clk_level,
  output logic powered_down,
  output logic sw_mode
);

  logic [2:0] start_s1_q;
  logic [2:0] start_s2_q;
  logic [2:0] start_prev_q;
  logic standby_n_s1_q;
  logic standby_n_s2_q;
  logic mode_s1_q;
  logic mode_s2_q;
  logic rst_s1_q;
  logic rst_s2_q;
  logic span_s1_q;
  logic span_s2_q;
  logic [31:0] ctrl_q;
  logic dev_o_q;
  logic dev_oe_q;
  logic clk_out_en;
  logic seq_mode;

  // Every pin passes a two-stage synchroniser before use.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      start_s1_q <= 3'h0;
      start_s2_q <= 3'h0;
      standby_n_s1_q <= 1'b0;
      standby_n_s2_q <= 1'b0;
      mode_s1_q <= 1'b0;
      mode_s2_q <= 1'b0;
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
      span_s1_q <= 1'b0;
      span_s2_q <= 1'b0;
    end
    else
    begin
      start_s1_q <= link.conv_start;
      start_s2_q <= start_s1_q;
      standby_n_s1_q <= link.standby_n;
      standby_n_s2_q <= standby_n_s1_q;
      mode_s1_q <= link.pin_or_register_control_select;
      mode_s2_q <= mode_s1_q;
      rst_s1_q <= link.reset;
      rst_s2_q <= rst_s1_q;
      span_s1_q <= link.span_or_conv_clock_pin;
      span_s2_q <= span_s1_q;
    end
  end

  // Previous synchronised start level, for rising-edge detection.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      start_prev_q <= 3'h0;
    else
      start_prev_q <= start_s2_q;
  end

  // Control register: pin reset restores it, otherwise software may write it, in software mode only.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b || rst_s2_q)
      ctrl_q <= conv_ctrl_pkg::CTRL_RESET_VAL;
    else if (ctrl_wr && mode_s2_q)
      ctrl_q <= ctrl_wdata;
  end

  assign seq_mode = ctrl_q[conv_ctrl_pkg::SEQ_MODE_POS];
  assign clk_out_en = ctrl_q[conv_ctrl_pkg::CLK_OUT_POS];

  // One conversion engine per pair.
  genvar gi;
  generate
    for (gi = 0; gi < conv_ctrl_pkg::NUM_PAIRS; gi++)
    begin : g_pair
      conv_ctrl_pkg::pair_state_t state_q;
      logic [7:0] cnt_q;
      logic rise;
      logic allowed;

      assign rise = start_s2_q[gi] && !start_prev_q[gi];
      // Hardware mode lets every pair start; software mode only pair C in sequential mode.
      assign allowed = !mode_s2_q || (gi == conv_ctrl_pkg::PAIR_C && seq_mode);

      always_ff @(posedge clk_sys)
      begin
        if (!rst_b || rst_s2_q || !standby_n_s2_q)
        begin
          state_q <= conv_ctrl_pkg::PAIR_IDLE;
          cnt_q <= 8'h00;
        end
        else
        begin
          unique case (state_q)
            conv_ctrl_pkg::PAIR_IDLE,
            conv_ctrl_pkg::PAIR_PDOWN:
            begin
              if (rise && allowed)
              begin
                state_q <= conv_ctrl_pkg::PAIR_CONV;
                cnt_q <= conv_ctrl_pkg::CONV_CYC_V;
              end
            end
            conv_ctrl_pkg::PAIR_CONV:
            begin
              // New edges are not looked at while converting.
              if (!start_s2_q[gi])
                state_q <= conv_ctrl_pkg::PAIR_PDOWN;
              else if (cnt_q == 8'h01)
                state_q <= conv_ctrl_pkg::PAIR_IDLE;
              else
                cnt_q <= cnt_q - 8'h01;
            end
          endcase
        end
      end

      // Status outputs for this pair, all registered.
      always_ff @(posedge clk_sys)
      begin
        if (!rst_b)
        begin
          pair_busy[gi] <= 1'b0;
          pair_done[gi] <= 1'b0;
          pair_pdown[gi] <= 1'b0;
        end
        else
        begin
          pair_busy[gi] <= (state_q == conv_ctrl_pkg::PAIR_CONV);
          pair_done[gi] <= (state_q == conv_ctrl_pkg::PAIR_CONV) && start_s2_q[gi] &&
                           (cnt_q == 8'h01) && !rst_s2_q && standby_n_s2_q;
          pair_pdown[gi] <= (state_q == conv_ctrl_pkg::PAIR_PDOWN);
        end
      end

      // Span selection: pin in hardware mode, register range bit in software mode.
      always_ff @(posedge clk_sys)
      begin
        if (!rst_b)
          span_narrow[gi] <= 1'b0;
        else if (!mode_s2_q)
          span_narrow[gi] <= span_s2_q;
        else
          span_narrow[gi] <= ctrl_q[conv_ctrl_pkg::SPAN_BITS_POS + gi];
      end
    end
  endgenerate

  // Range/clock pin drive: internal clock out only in software mode with the bit set.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      dev_oe_q <= 1'b0;
      dev_o_q <= 1'b0;
      ext_clk_level <= 1'b0;
    end
    else
    begin
      dev_oe_q <= mode_s2_q && clk_out_en;
      dev_o_q <= int_conv_clk;
      ext_clk_level <= mode_s2_q && !clk_out_en && span_s2_q;
    end
  end

  assign link.span_dev_o = dev_o_q;
  assign link.span_dev_oe = dev_oe_q;

  // Mirrors of mode, standby and control register.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      powered_down <= 1'b1;
      sw_mode <= 1'b0;
      control_register <= conv_ctrl_pkg::CTRL_RESET_VAL;
    end
    else
    begin
      powered_down <= !standby_n_s2_q;
      sw_mode <= mode_s2_q;
      control_register <= ctrl_q;
    end
  end

endmodule : conv_ctrl_device

// File: conv_ctrl_host.sv
`timescale 1ns/1ps
module conv_ctrl_host (
  input wire logic clk_sys,
  input wire logic rst_b,
  conv_ctrl_if.host link,
  input wire logic [2:0] start_req,
  input wire logic [2:0] start_hold,
  input wire logic standby_req_n,
  input wire logic sw_mode_req,
  input wire logic reset_req,
  input wire logic span_drive_en,
  input wire logic span_level,
  output logic reset_busy
);

  logic [2:0] start_q;
  logic standby_n_q;
  logic mode_q;
  logic rst_q;
  logic [7:0] rst_cnt_q;
  logic span_o_q;
  logic span_oe_q;

  // Start lines rise on request and stay high while hold is given.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      start_q <= 3'h0;
    else
      start_q <= start_req | (start_q & start_hold);
  end

  // Reset pulse lasts at least the minimum number of cycles.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      rst_q <= 1'b0;
      rst_cnt_q <= 8'h00;
    end
    else if (reset_req && !rst_q)
    begin
      rst_q <= 1'b1;
      rst_cnt_q <= conv_ctrl_pkg::RESET_MIN_V;
    end
    else if (rst_cnt_q > 8'h01)
      rst_cnt_q <= rst_cnt_q - 8'h01;
    else
    begin
      rst_q <= 1'b0;
      rst_cnt_q <= 8'h00;
    end
  end

  // Static levels and the range/clock drive.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      standby_n_q <= 1'b1;
      mode_q <= 1'b0;
      span_o_q <= 1'b0;
      span_oe_q <= 1'b1;
    end
    else
    begin
      standby_n_q <= standby_req_n;
      mode_q <= sw_mode_req;
      span_o_q <= span_level;
      span_oe_q <= span_drive_en;
    end
  end

  assign link.conv_start = start_q;
  assign link.standby_n = standby_n_q;
  assign link.pin_or_register_control_select = mode_q;
  assign link.reset = rst_q;
  assign link.span_host_o = span_o_q;
  assign link.span_host_oe = span_oe_q;
  assign reset_busy = rst_q;

endmodule : conv_ctrl_host

// File: conv_ctrl_if.sv
`timescale 1ns/1ps
interface conv_ctrl_if;
  logic [2:0] conv_start;
  logic standby_n;
  logic pin_or_register_control_select;
  logic reset;
  logic span_host_o;
  logic span_host_oe;
  logic span_dev_o;
  logic span_dev_oe;
  logic span_or_conv_clock_pin;

  // Resolve the shared range/clock wire from both enables; host wins on contention.
  assign span_or_conv_clock_pin = span_host_oe ? span_host_o : (span_dev_oe ? span_dev_o : 1'b0);

  modport device (
    input conv_start,
    input standby_n,
    input pin_or_register_control_select,
    input reset,
    input span_or_conv_clock_pin,
    output span_dev_o,
    output span_dev_oe
  );

  modport host (
    output conv_start,
    output standby_n,
    output pin_or_register_control_select,
    output reset,
    output span_host_o,
    output span_host_oe,
    input span_or_conv_clock_pin
  );
endinterface : conv_ctrl_if

// File: conv_ctrl_pkg.sv
package conv_ctrl_pkg;

  // Number of converter pairs (A, B, C).
  localparam int unsigned NUM_PAIRS = 3;
  localparam int unsigned PAIR_A = 0;
  localparam int unsigned PAIR_B = 1;
  localparam int unsigned PAIR_C = 2;

  // Control register width and the value loaded on reset.
  localparam int unsigned CTRL_W = 32;
  localparam logic [31:0] CTRL_RESET_VAL = 32'h000003FF;

  // Field positions inside the control register.
  localparam int unsigned SEQ_MODE_POS = 23;
  localparam int unsigned CLK_OUT_POS = 20;
  // First of the three software span bits, one per pair from A upwards.
  localparam int unsigned SPAN_BITS_POS = 26;

  // Clock rate and timing figures.
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned RESET_MIN_NS = 50;
  localparam int unsigned RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CONV_TIME_NS = 1200;
  localparam int unsigned CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CONV_CNT_W = 8;
  localparam logic [7:0] CONV_CYC_V = 8'(CONV_CYC);
  localparam logic [7:0] RESET_MIN_V = 8'(RESET_MIN_CYC);

  // Per-pair conversion state.
  typedef enum logic [1:0] {
    PAIR_IDLE,
    PAIR_CONV,
    PAIR_PDOWN
  } pair_state_t;

endpackage : conv_ctrl_pkg
